// file: design/ric_pkg.sv
// Shared constants, types and CRC arithmetic for the identity-code link.
// Assumes one 200 MHz clock on both ends of the link.
package ric_pkg;
    localparam int FAM_W = 8;
    localparam int SER_W = 48;
    localparam int BODY_W = 56;
    localparam int ID_W = 64;
    localparam int CNT_W = 6;
    localparam logic [7:0] CRC_INIT = 8'h00;
    // x^8 + x^5 + x^4 + 1 in right-shifting form
    localparam logic [7:0] CRC_TAPS = 8'h8c;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [CNT_W-1:0] ID_LAST = 6'h3f;
    localparam logic [1:0] PH_A = 2'h0;
    localparam logic [1:0] PH_B = 2'h1;
    localparam logic [1:0] PH_W = 2'h2;
    // Selection command bytes
    localparam logic [7:0] CMD_READ_ID = 8'h01;
    localparam logic [7:0] CMD_MATCH = 8'h02;
    localparam logic [7:0] CMD_SEARCH = 8'h03;
    localparam logic [7:0] CMD_SKIP = 8'h04;
    localparam logic [7:0] CMD_RESUME = 8'h05;
    localparam logic [7:0] CMD_OD_SKIP = 8'h06;
    localparam logic [7:0] CMD_OD_MATCH = 8'h07;
    // Memory-level commands occupy MEM_CMD_BASE .. MEM_CMD_BASE + 7
    localparam logic [7:0] MEM_CMD_BASE = 8'h10;
    localparam logic [4:0] MEM_CMD_HI = 5'h02;
    // Bit rates and derived slot spacing
    localparam int CLK_HZ = 200_000_000;
    localparam int STD_RATE_BPS = 15_400;
    localparam int OD_RATE_BPS = 125_000;
    localparam int STD_BIT_CYC = CLK_HZ / STD_RATE_BPS;
    localparam int OD_BIT_CYC = CLK_HZ / OD_RATE_BPS;
    localparam int DIV_W = 16;

    typedef enum logic [2:0] {
        OP_READ_ID, OP_MATCH, OP_SEARCH, OP_SKIP,
        OP_RESUME, OP_OD_SKIP, OP_OD_MATCH, OP_BYTE
    } ric_op_t;

    // One shift step toward the LSB with feedback into top bit and taps
    function automatic logic [7:0] crc8_step(logic [7:0] r, logic b);
        logic fb;
        fb = b ^ r[0]; // [R9]
        return {1'b0, r[7:1]} ^ (fb ? CRC_TAPS : 8'h00); // [R2] [R9]
    endfunction

    // Code body is shifted from bit 0 upward: family LSB first, then serial
    function automatic logic [7:0] crc8_block(logic [BODY_W-1:0] d);
        logic [7:0] r;
        r = CRC_INIT; // [R3]
        for (int i = 0; i < BODY_W; i++) begin
            r = crc8_step(r, d[i]); // [R4]
        end
        return r;
    endfunction

    function automatic logic is_mem_cmd(logic [7:0] b);
        return b[7:3] == MEM_CMD_HI;
    endfunction

    function automatic logic [7:0] op_code(ric_op_t op);
        logic [7:0] c;
        c = CMD_SKIP;
        unique case (op)
            OP_READ_ID: c = CMD_READ_ID;
            OP_MATCH: c = CMD_MATCH;
            OP_SEARCH: c = CMD_SEARCH;
            OP_SKIP: c = CMD_SKIP;
            OP_RESUME: c = CMD_RESUME;
            OP_OD_SKIP: c = CMD_OD_SKIP;
            OP_OD_MATCH: c = CMD_OD_MATCH;
            OP_BYTE: c = MEM_CMD_BASE;
        endcase
        return c;
    endfunction
endpackage

// file: design/ric_link_if.sv
// Abstract bit-slot link between the bus master and the identity device.
// The master times every slot; the device only answers.
`timescale 1ns/100ps
interface ric_link_if;
    logic start;
    logic start_std;
    logic slot;
    logic slot_wr;
    logic m_bit;
    logic d_bit;
    logic d_ready;
    logic d_od;
    modport dev(input start, start_std, slot, slot_wr, m_bit,
                output d_bit, d_ready, d_od);
    modport host(output start, start_std, slot, slot_wr, m_bit,
                 input d_bit, d_ready, d_od);
endinterface

// file: design/ric_dev.sv
// Identity device end: fixed identity code, selection commands, speed
// switch and an 8-word buffer for memory-level traffic.
// Assumes the master keeps slots far apart and honours d_ready.
`timescale 1ns/100ps

module ric_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

    if (DEPTH < 2 || W < 1) begin : g_bad
        $error("ric_fifo needs DEPTH >= 2 and W >= 1");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } ric_fst_t;

    ric_fst_t r_reg, r_next;
    logic do_push, do_pop;

    function automatic logic [AW-1:0] ptr_inc(logic [AW-1:0] p);
        return (p == PTR_LAST) ? '0 : p + 1'b1;
    endfunction

    assign in_ready = r_reg.cnt != CNT_FULL;
    assign out_valid = r_reg.cnt != '0;
    assign out_data = r_reg.mem[r_reg.rp];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    always_comb begin
        r_next = r_reg;
        if (do_push) begin
            r_next.mem[r_reg.wp] = in_data;
            r_next.wp = ptr_inc(r_reg.wp);
        end
        if (do_pop) begin
            r_next.rp = ptr_inc(r_reg.rp);
        end
        if (do_push && !do_pop) begin
            r_next.cnt = r_reg.cnt + 1'b1;
        end else if (do_pop && !do_push) begin
            r_next.cnt = r_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_next_check: r_reg <= r_next;
        end
    end
endmodule

// Operation
// R1: Code is family, serial, then CRC byte
// R2: CRC uses x^8+x^5+x^4+1 feedback register
// R3: CRC register starts cleared to zero
// R4: Family LSB first, then serial, gives CRC
// R5: Receiver shifts CRC in, expects zero
// R6: All link bits travel LSB first
// R7: Overdrive command switches to fast rate
// R8: Selection command must precede memory commands
// R9: Shift right, feedback into top and taps
module ric_dev
    import ric_pkg::*;
#(
    parameter logic [FAM_W-1:0] FAMILY_CODE = 8'h5a, // arbitrary value
    parameter logic [SER_W-1:0] SERIAL_NUM = 48'h0123_4567_89ab, // arbitrary
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link to the bus master
    ric_link_if.dev link,
    // Received memory-level bytes
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    // Status
    output logic mem_open,
    output logic selected,
    output logic [ric_pkg::ID_W-1:0] id_code
);
    import ric_pkg::*;

    localparam logic [BODY_W-1:0] BODY = {SERIAL_NUM, FAMILY_CODE};
    localparam logic [ID_W-1:0] ID_CODE = {crc8_block(BODY), BODY}; // [R1]

    typedef enum logic [2:0] {
        D_IDLE, D_CMD, D_SEND, D_MATCH, D_SRCH, D_MEM, D_DATA, D_OFF
    } ric_dst_t;

    typedef struct packed {
        ric_dst_t st;
        logic [7:0] sh;
        logic [ID_W-1:0] id;
        logic [CNT_W-1:0] cnt;
        logic [1:0] ph;
        logic miss;
        logic sel;
        logic od;
        logic dbit;
        logic push;
        logic [7:0] pdata;
    } ric_dstate_t;

    ric_dstate_t r_reg, r_next;
    logic fifo_in_ready;
    logic [7:0] bt;
    logic byte_end;
    logic id_end;
    logic miss_n;

    // Byte assembly shared by the command states, LSB arrives first
    assign bt = {link.m_bit, r_reg.sh[7:1]}; // [R6]
    assign byte_end = r_reg.cnt[2:0] == BYTE_LAST;
    assign id_end = r_reg.cnt == ID_LAST;
    assign miss_n = r_reg.miss | (link.m_bit ^ r_reg.id[0]);

    always_comb begin
        r_next = r_reg;
        r_next.push = 1'b0;
        if (link.start) begin
            // A new transaction always begins with a selection command
            r_next.st = D_CMD; // [R8]
            r_next.cnt = '0;
            if (link.start_std) begin
                r_next.od = 1'b0;
            end
        end else if (link.slot) begin
            unique case (r_reg.st)
                D_CMD: if (link.slot_wr) begin
                    r_next.sh = bt;
                    r_next.cnt = r_reg.cnt + 1'b1;
                    if (byte_end) begin
                        r_next.cnt = '0;
                        r_next.id = ID_CODE;
                        r_next.dbit = ID_CODE[0];
                        r_next.miss = 1'b0;
                        r_next.ph = PH_A;
                        unique case (bt)
                            CMD_READ_ID: r_next.st = D_SEND;
                            CMD_MATCH, CMD_OD_MATCH: r_next.st = D_MATCH;
                            CMD_SEARCH: r_next.st = D_SRCH;
                            CMD_SKIP, CMD_OD_SKIP: r_next.st = D_MEM; // [R8]
                            CMD_RESUME: r_next.st = r_reg.sel ? D_MEM : D_OFF;
                            default: r_next.st = D_OFF;
                        endcase
                        // Speed changes only once the whole byte is in
                        if (bt == CMD_OD_SKIP || bt == CMD_OD_MATCH) begin
                            r_next.od = 1'b1; // [R7]
                        end
                    end
                end
                D_SEND: if (!link.slot_wr) begin
                    r_next.id = {1'b0, r_reg.id[ID_W-1:1]}; // [R6]
                    r_next.dbit = r_reg.id[1];
                    r_next.cnt = r_reg.cnt + 1'b1;
                    if (id_end) begin
                        r_next.st = D_MEM; // [R8]
                        r_next.cnt = '0;
                    end
                end
                D_MATCH: if (link.slot_wr) begin
                    // Keep listening after a miss so the bit count stays true
                    r_next.miss = miss_n;
                    r_next.id = {1'b0, r_reg.id[ID_W-1:1]};
                    r_next.cnt = r_reg.cnt + 1'b1;
                    if (id_end) begin
                        r_next.st = miss_n ? D_OFF : D_MEM; // [R8]
                        r_next.sel = !miss_n;
                        r_next.cnt = '0;
                    end
                end
                D_SRCH: begin
                    if (r_reg.ph == PH_A && !link.slot_wr) begin
                        r_next.dbit = !r_reg.id[0];
                        r_next.ph = PH_B;
                    end else if (r_reg.ph == PH_B && !link.slot_wr) begin
                        r_next.ph = PH_W;
                    end else if (r_reg.ph == PH_W && link.slot_wr) begin
                        r_next.ph = PH_A;
                        if (link.m_bit != r_reg.id[0]) begin
                            r_next.st = D_OFF;
                            r_next.sel = 1'b0;
                        end else begin
                            r_next.id = {1'b0, r_reg.id[ID_W-1:1]};
                            r_next.dbit = r_reg.id[1];
                            r_next.cnt = r_reg.cnt + 1'b1;
                            if (id_end) begin
                                r_next.st = D_MEM; // [R8]
                                r_next.sel = 1'b1;
                                r_next.cnt = '0;
                            end
                        end
                    end
                end
                D_MEM, D_DATA: if (link.slot_wr) begin
                    r_next.sh = bt;
                    r_next.cnt = r_reg.cnt + 1'b1;
                    if (byte_end) begin
                        r_next.cnt = '0;
                        // Unknown command bytes close the device until restart
                        if (r_reg.st == D_DATA || is_mem_cmd(bt)) begin
                            r_next.push = 1'b1;
                            r_next.pdata = bt;
                            r_next.st = D_DATA;
                        end else begin
                            r_next.st = D_OFF;
                        end
                    end
                end
                D_IDLE, D_OFF: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // Ready also drops while a push is pending, so a byte is never lost
    assign link.d_ready = fifo_in_ready && !r_reg.push;
    assign link.d_bit = r_reg.dbit;
    assign link.d_od = r_reg.od;
    assign mem_open = r_reg.st == D_MEM || r_reg.st == D_DATA;
    assign selected = r_reg.sel;
    assign id_code = ID_CODE;

    ric_fifo #(
        .W(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(r_reg.push),
        .in_ready(fifo_in_ready),
        .in_data(r_reg.pdata),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );
endmodule

// file: design/ric_host.sv
// Bus master end: times bit slots at standard or overdrive rate, sends
// selection and memory bytes, reads and checks the identity code.
// Assumes the device end answers on the same clock.
`timescale 1ns/100ps
module ric_host
    import ric_pkg::*;
#(
    parameter int STD_CYC = STD_BIT_CYC,
    parameter int OD_CYC = OD_BIT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire ric_pkg::ric_op_t cmd_op,
    input wire logic cmd_std,
    input wire logic [7:0] cmd_byte,
    input wire logic [ric_pkg::ID_W-1:0] cmd_id,
    // Results
    output logic done,
    output logic id_ok,
    output logic [ric_pkg::ID_W-1:0] id_out,
    output logic od_mode,
    // Link to the device
    ric_link_if.host link
);
    import ric_pkg::*;

    if (STD_CYC < 2 || OD_CYC < 2 || STD_CYC >= 2**DIV_W ||
        OD_CYC >= 2**DIV_W) begin : g_bad
        $error("ric_host slot spacing out of range");
    end

    typedef enum logic [2:0] {
        H_IDLE, H_START, H_CMD, H_RD, H_WR, H_SRCH
    } ric_hst_t;

    typedef struct packed {
        ric_hst_t st;
        ric_op_t op;
        logic std;
        logic [7:0] sh;
        logic [ID_W-1:0] tgt;
        logic [ID_W-1:0] rx;
        logic [7:0] crc;
        logic [CNT_W-1:0] cnt;
        logic [1:0] ph;
        logic a;
        logic ch;
        logic [DIV_W-1:0] div;
        logic od;
        logic start;
        logic slot;
        logic wr;
        logic mbit;
        logic done;
        logic ok;
        logic [ID_W-1:0] id_out;
    } ric_hstate_t;

    ric_hstate_t r_reg, r_next;
    logic tick;
    logic b;
    logic [7:0] crc_n;
    logic [ID_W-1:0] rx_n;

    assign tick = r_reg.div == '0;
    assign b = (r_reg.st == H_SRCH) ? r_reg.ch : link.d_bit;
    assign crc_n = crc8_step(r_reg.crc, b); // [R2]
    assign rx_n = {b, r_reg.rx[ID_W-1:1]}; // [R4] [R6]

    always_comb begin
        r_next = r_reg;
        r_next.start = 1'b0;
        r_next.slot = 1'b0;
        r_next.done = 1'b0;
        if (!tick) begin
            r_next.div = r_reg.div - 1'b1;
        end
        if (r_reg.st == H_IDLE) begin
            if (cmd_valid) begin
                r_next.op = cmd_op;
                r_next.std = cmd_std;
                r_next.sh = (cmd_op == OP_BYTE) ? cmd_byte : op_code(cmd_op);
                r_next.tgt = cmd_id;
                r_next.cnt = '0;
                r_next.ok = 1'b0;
                // Only raw bytes may skip the opening selection command
                r_next.st = (cmd_op == OP_BYTE) ? H_CMD : H_START; // [R8]
            end
        end else if (r_reg.slot && !r_reg.wr) begin
            // Read slot: device bit is valid while our slot pulse is out
            if (r_reg.st == H_RD) begin
                r_next.rx = rx_n;
                r_next.crc = crc_n;
                r_next.cnt = r_reg.cnt + 1'b1;
                if (r_reg.cnt == ID_LAST) begin
                    r_next.st = H_IDLE;
                    r_next.done = 1'b1;
                    r_next.ok = crc_n == CRC_INIT; // [R5]
                    r_next.id_out = rx_n;
                end
            end else if (r_reg.ph == PH_A) begin
                r_next.a = link.d_bit;
                r_next.ph = PH_B;
            end else begin
                r_next.ph = PH_W;
                // Two zero bits would mean a conflict; follow the target then (two ones end the search)
                r_next.ch = (r_reg.a != link.d_bit) ? r_reg.a : r_reg.tgt[0];
                if (r_reg.a && link.d_bit) begin
                    r_next.st = H_IDLE;
                    r_next.done = 1'b1;
                end
            end
        end else if (tick && (r_reg.st == H_START || link.d_ready)) begin
            r_next.div = DIV_W'(r_reg.od ? OD_CYC - 1 : STD_CYC - 1);
            unique case (r_reg.st)
                H_START: begin
                    r_next.start = 1'b1;
                    if (r_reg.std) begin
                        r_next.od = 1'b0;
                    end
                    r_next.st = H_CMD;
                end
                H_CMD: begin
                    r_next.slot = 1'b1;
                    r_next.wr = 1'b1;
                    r_next.mbit = r_reg.sh[0]; // [R6]
                    r_next.sh = {1'b0, r_reg.sh[7:1]};
                    r_next.cnt = r_reg.cnt + 1'b1;
                    if (r_reg.cnt[2:0] == BYTE_LAST) begin
                        r_next.cnt = '0;
                        r_next.crc = CRC_INIT; // [R3]
                        r_next.ph = PH_A;
                        if (r_reg.op == OP_OD_SKIP ||
                                r_reg.op == OP_OD_MATCH) begin
                            r_next.od = 1'b1; // [R7]
                        end
                        unique case (r_reg.op)
                            OP_READ_ID: r_next.st = H_RD;
                            OP_MATCH, OP_OD_MATCH: r_next.st = H_WR;
                            OP_SEARCH: r_next.st = H_SRCH;
                            default: begin
                                r_next.st = H_IDLE;
                                r_next.done = 1'b1;
                                r_next.ok = 1'b1;
                            end
                        endcase
                    end
                end
                H_RD: begin
                    r_next.slot = 1'b1;
                    r_next.wr = 1'b0;
                end
                H_WR, H_SRCH: begin
                    r_next.slot = 1'b1;
                    r_next.wr = r_reg.st == H_WR || r_reg.ph == PH_W;
                    r_next.mbit = (r_reg.st == H_WR) ? r_reg.tgt[0] : r_reg.ch;
                    if (r_next.wr) begin
                        r_next.tgt = {1'b0, r_reg.tgt[ID_W-1:1]};
                        r_next.rx = rx_n;
                        r_next.crc = crc_n;
                        r_next.cnt = r_reg.cnt + 1'b1;
                        r_next.ph = PH_A;
                        if (r_reg.cnt == ID_LAST) begin
                            r_next.st = H_IDLE;
                            r_next.done = 1'b1;
                            r_next.ok = (r_reg.st == H_WR) ||
                                        (crc_n == CRC_INIT);
                            r_next.id_out = rx_n;
                        end
                    end
                end
                H_IDLE: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign cmd_ready = r_reg.st == H_IDLE;
    assign done = r_reg.done;
    assign id_ok = r_reg.ok;
    assign id_out = r_reg.id_out;
    assign od_mode = r_reg.od;
    assign link.start = r_reg.start;
    assign link.start_std = r_reg.std;
    assign link.slot = r_reg.slot;
    assign link.slot_wr = r_reg.wr;
    assign link.m_bit = r_reg.mbit;
endmodule

// file: design/ric_dev_fix_note.sv
// Holds no logic; the two link ends are in ric_dev.sv and ric_host.sv.
// Assumes nothing of its surroundings.

// file: tb/ric_link_checker.sv
// Assertions on the link between master and device ends.
// Assumes one clock and slots at least nine cycles apart.
`timescale 1ns/100ps
module ric_link_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link
    input wire logic start,
    input wire logic start_std,
    input wire logic slot,
    input wire logic slot_wr,
    input wire logic m_bit,
    input wire logic d_bit,
    input wire logic d_ready,
    input wire logic d_od
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_start_pulse: assert property (start |=> !start)
        else $error("start too long");
    a_slot_pulse: assert property (slot |=> !slot)
        else $error("slot too long");
    a_start_gap: assert property (start |=> !slot [*8])
        else $error("slot too soon after start");
    a_slot_gap: assert property (slot |=> !slot [*8])
        else $error("slots too close");
    a_od_set: assert property ($rose(d_od) |-> $past(slot && slot_wr))
        else $error("overdrive set without command bit");
    a_od_stable: assert property (!slot && !start |=> $stable(d_od))
        else $error("overdrive changed between slots");
    a_od_clear: assert property (start && start_std |=> !d_od)
        else $error("overdrive kept after standard start");
    a_od_keep: assert property (start && !start_std |=> $stable(d_od))
        else $error("overdrive lost on fast start");
    a_dbit_hold: assert property (
        !slot && !start && !$past(slot) |=> $stable(d_bit))
        else $error("device bit moved without slot");
    c_od: cover property ($rose(d_od));
    c_read: cover property (slot && !slot_wr && d_bit);
    c_full: cover property (!d_ready && !m_bit);
endmodule

// file: tb/testbench.sv
// Self-checking bench: master and device ends joined by the link.
// Assumes slot spacing shortened to 20 and 10 cycles.
`timescale 1ns/100ps
module testbench;
    import ric_pkg::*;
    typedef struct {
        ric_op_t op;
        logic std;
        logic [7:0] code;
        logic od;
    } ric_row_t;
    localparam logic [7:0] FAM = 8'h5a; // arbitrary value
    localparam logic [47:0] SER = 48'h0123_4567_89ab; // arbitrary value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    ric_op_t cmd_op = OP_SKIP;
    logic cmd_std = 1'b1;
    logic [7:0] cmd_byte = 8'h00;
    logic [63:0] cmd_id = 64'h0;
    logic rx_ready = 1'b0;
    logic cmd_ready, done, id_ok, od_mode, rx_valid, mem_open, selected;
    logic [63:0] id_out, id_code, id_exp, rd_sh;
    logic [7:0] rx_data, cmd_sh;
    int n_fail = 0;
    int check_count = 0;
    int wcnt = 0;
    int rcnt = 0;
    ric_row_t rows [8];
    ric_link_if link ();
    always #2.5 clk = ~clk;
    ric_host #(.STD_CYC(20), .OD_CYC(10)) u_ric_host (
        .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_std(cmd_std),
        .cmd_byte(cmd_byte), .cmd_id(cmd_id), .done(done), .id_ok(id_ok),
        .id_out(id_out), .od_mode(od_mode), .link(link));
    ric_dev #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER)) u_ric_dev (
        .clk(clk), .rst_n(rst_n), .link(link), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .mem_open(mem_open),
        .selected(selected), .id_code(id_code));
    ric_link_checker u_ric_link_checker (
        .clk(clk), .rst_n(rst_n), .start(link.start),
        .start_std(link.start_std), .slot(link.slot),
        .slot_wr(link.slot_wr), .m_bit(link.m_bit), .d_bit(link.d_bit),
        .d_ready(link.d_ready), .d_od(link.d_od));
    // Wire-side capture, bits placed LSB first
    always @(posedge clk) begin
        if (link.start) begin
            wcnt <= 0;
            rcnt <= 0;
        end else if (link.slot && link.slot_wr && wcnt < 8) begin
            cmd_sh[wcnt[2:0]] <= link.m_bit;
            wcnt <= wcnt + 1;
        end else if (link.slot && !link.slot_wr && rcnt < 64) begin
            rd_sh[rcnt[5:0]] <= link.d_bit;
            rcnt <= rcnt + 1;
        end
    end
    function automatic logic [7:0] ref_crc(logic [63:0] v, int n);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < n; i++) begin
            r = (r >> 1) ^ ((v[i] ^ r[0]) ? 8'h8c : 8'h00);
        end
        return r;
    endfunction
    task automatic chk(logic [63:0] seen, logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic run(ric_op_t op, logic s, logic [7:0] b, logic [63:0] id);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_std <= s;
        cmd_byte <= b;
        cmd_id <= id;
        do begin
            @(posedge clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 9000);
        cmd_valid <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 9000);
        if (n >= 9000) begin
            n_fail++;
            end_sim();
        end
        repeat (2) @(posedge clk);
    endtask
    initial begin
        rows = '{'{OP_READ_ID, 1'b1, 8'h01, 1'b0},
                 '{OP_SKIP, 1'b1, 8'h04, 1'b0},
                 '{OP_MATCH, 1'b1, 8'h02, 1'b0},
                 '{OP_SEARCH, 1'b1, 8'h03, 1'b0},
                 '{OP_RESUME, 1'b1, 8'h05, 1'b0},
                 '{OP_OD_SKIP, 1'b1, 8'h06, 1'b1},
                 '{OP_SKIP, 1'b0, 8'h04, 1'b1},
                 '{OP_OD_MATCH, 1'b1, 8'h07, 1'b1}};
        id_exp = {ref_crc({8'h00, SER, FAM}, 56), SER, FAM};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        chk(ref_crc(id_code, 64), 64'h0);
        chk(id_code, id_exp);
        foreach (rows[i]) begin
            run(rows[i].op, rows[i].std, 8'h00, id_exp);
            chk(cmd_sh, rows[i].code);
            chk(mem_open, 1'b1);
            chk({od_mode, link.d_od}, {2{rows[i].od}});
            if (rows[i].op == OP_READ_ID) begin
                chk(rd_sh, id_exp);
            end
            if (rows[i].op == OP_READ_ID || rows[i].op == OP_SEARCH) begin
                chk(id_ok, 1'b1);
                chk(id_out, id_exp);
            end
        end
        // Reset in mid-run, while in overdrive
        rst_n <= 1'b0;
        @(posedge clk);
        chk({od_mode, link.d_od, mem_open, selected}, 4'h0);
        chk({cmd_ready, link.d_ready}, 2'h3);
        rst_n <= 1'b1;
        run(OP_MATCH, 1'b1, 8'h00, id_exp ^ 64'h1);
        chk({mem_open, selected}, 2'h0);
        run(OP_RESUME, 1'b1, 8'h00, id_exp);
        chk(mem_open, 1'b0);
        // Fill the buffer with all eight memory commands, then drain
        run(OP_SKIP, 1'b1, 8'h00, id_exp);
        for (int i = 0; i < 8; i++) begin
            run(OP_BYTE, 1'b1, 8'h10 + 8'(i), id_exp);
        end
        chk({rx_valid, link.d_ready}, 2'h2);
        rx_ready <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            chk({rx_valid, rx_data}, {1'b1, 8'h10 + 8'(i)});
        end
        rx_ready <= 1'b0;
        @(posedge clk);
        chk(rx_valid, 1'b0);
        // An unknown first memory byte leaves the device deaf
        run(OP_SKIP, 1'b1, 8'h00, id_exp);
        run(OP_BYTE, 1'b1, 8'h20, id_exp);
        run(OP_BYTE, 1'b1, 8'h10, id_exp);
        chk({rx_valid, mem_open}, 2'h0);
        end_sim();
    end
endmodule
